//--- verilog/wdt_pkg.sv
// shared constants for the watchdog block
package wdt_pkg;
    // register offsets (plain register port, byte-wide registers)
    localparam logic [3:0] ADDR_WDT_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_RESET_FLAGS = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    localparam logic [3:0] ADDR_OSC_CTRL = 4'h5;
    // reset values
    localparam logic [7:0] WDT_CONTROL_RST = 8'h53;
    localparam logic [7:0] RESET_FLAGS_RST = 8'h00;
    // field positions
    localparam int KEY_LSB = 3;
    localparam int SEL_LSB = 0;
    localparam int FLAG_KEY_FAULT_BIT = 0;
    localparam int FLAG_LOW_VOLT_BIT = 2;
    localparam int FLAG_VSEL_FAULT_BIT = 1;
    localparam int FLAG_KEEP_IDLE_BIT = 7;
    localparam int ST_OVERFLOW_BIT = 0;
    localparam int ST_POWER_DOWN_BIT = 1;
    localparam int ST_FAST_READY_BIT = 2;
    localparam int ST_SLOW_READY_BIT = 3;
    localparam int ST_WDT_ON_BIT = 4;
    // key codes
    localparam logic [4:0] KEY_DISABLE = 5'h15;
    localparam logic [4:0] KEY_ENABLE = 5'h0a;
    // timing: sub clock about 32 kHz, core clock 125 MHz
    localparam int CLK_HZ = 125000000;
    localparam int SUB_HZ = 32000;
    localparam int SUB_DIV = CLK_HZ / SUB_HZ;
    // key fault reset fires after this many slow osc ticks (2 to 3)
    localparam int KEY_FAULT_TICKS = 2;
    // counter width that covers 2^18 periods
    localparam int WDT_CNT_W = 19;
    // shared oscillator settle period in sub clock ticks
    localparam int SETTLE_TICKS = 1024;
    // event bits of the interrupt status register
    localparam int EV_OVERFLOW = 0;
    localparam int EV_KEY_FAULT = 1;
    localparam int EV_FAST_READY = 2;
    localparam int EV_SLOW_READY = 3;
    // timeout select to bit position of overflow
    function automatic logic [4:0] timeout_bit(input logic [2:0] sel);
        unique case (sel)
            3'h0: timeout_bit = 5'd8;
            3'h1: timeout_bit = 5'd10;
            3'h2: timeout_bit = 5'd12;
            3'h3: timeout_bit = 5'd14;
            3'h4: timeout_bit = 5'd15;
            3'h5: timeout_bit = 5'd16;
            3'h6: timeout_bit = 5'd17;
            default: timeout_bit = 5'd18;
        endcase
    endfunction
endpackage

//--- verilog/settle_if.sv
// handshake between the watchdog core and the oscillator settle counter
`timescale 1ns/10ps
interface settle_if;
    logic tick;
    logic fast_start;
    logic slow_start;
    logic fast_ready;
    logic slow_ready;
    modport core (output tick, output fast_start, output slow_start,
        input fast_ready, input slow_ready);
    modport counter (input tick, input fast_start, input slow_start,
        output fast_ready, output slow_ready);
endinterface

//--- verilog/osc_settle.sv
// shared start-up settle counter for the fast and slow oscillators
`timescale 1ns/10ps
module osc_settle
    import wdt_pkg::*;
#(
    parameter int SETTLE = SETTLE_TICKS
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // link to the core
    settle_if.counter st
);
    typedef enum logic [1:0] {IDLE, FAST, SLOW} settle_t;
    settle_t state_r;
    logic [15:0] cnt_r;
    logic fast_pend_r;
    logic slow_pend_r;
    logic fast_rdy_r;
    logic slow_rdy_r;
    wire done = st.tick && (cnt_r == 16'(SETTLE - 1));

    assign st.fast_ready = fast_rdy_r;
    assign st.slow_ready = slow_rdy_r;

    // one counter serves both; slow waits until the fast period has finished
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= IDLE;
            cnt_r <= 16'h0000;
            fast_pend_r <= 1'b0;
            slow_pend_r <= 1'b0;
            fast_rdy_r <= 1'b0;
            slow_rdy_r <= 1'b0;
        end
        else
        begin
            if (st.fast_start)
            begin
                fast_pend_r <= 1'b1;
                fast_rdy_r <= 1'b0;
            end
            if (st.slow_start)
            begin
                slow_pend_r <= 1'b1;
                slow_rdy_r <= 1'b0;
            end
            unique case (state_r)
                IDLE:
                begin
                    cnt_r <= 16'h0000;
                    if (fast_pend_r)
                        state_r <= FAST; // [R11]
                    else if (slow_pend_r)
                        state_r <= SLOW;
                end
                FAST:
                begin
                    if (st.tick)
                        cnt_r <= cnt_r + 16'h0001;
                    if (done)
                    begin
                        fast_rdy_r <= 1'b1;
                        fast_pend_r <= 1'b0;
                        state_r <= IDLE;
                    end
                end
                SLOW:
                begin
                    if (st.tick)
                        cnt_r <= cnt_r + 16'h0001;
                    if (done)
                    begin
                        slow_rdy_r <= 1'b1;
                        slow_pend_r <= 1'b0;
                        state_r <= IDLE;
                    end
                end
            endcase
        end
    end

    chk_slow_after_fast: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
        (state_r == SLOW) |-> !fast_pend_r)
        else $error("slow settle ran while fast settle pending");
endmodule

//--- verilog/wdt_core.sv
// watchdog timer with key guard, reset flags and oscillator settle control
// How it works
// [R1] counter advances on the low-speed sub clock tick from slow RC or crystal
// [R2] timeout select picks 2^8,10,12,14,15,16,17,18 sub periods
// [R3] key 10101B disables, key 01010B enables the watchdog
// [R4] any other key resets device two slow ticks later, sets fault flag
// [R5] after power-on the key reads 01010B so watchdog starts enabled
// [R6] key fault flag is sticky at bit 0, only software zero clears it
// [R7] overflow in run mode gives full device reset and sets timeout flag
// [R8] overflow in sleep or idle sets flag, resets only pc and stack pointer
// [R9] counter cleared by invalid key, clear instruction or halt
// [R10] bits 6 to 3 of the reset flags register read as zero
// [R11] fast and slow oscillators share one settle counter, fast first
// [R12] after deep sleep wake, first instruction waits for fast ready flag
// [R13] sleep-with-watchdog wake on fast crystal with fast start may use slow RC
// [R14] system-clocked peripherals follow the system clock to the sub clock
// [R15] sub clock runs only while the watchdog is enabled
// [R16] halt sets power-down flag; power-up or clear instruction clears it
// [R17] watchdog is an up-counter, overflow taken at the selected bit
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module wdt_core
    import wdt_pkg::*;
#(
    parameter int DIV = SUB_DIV,
    parameter int SETTLE = SETTLE_TICKS
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // cpu events and modes
    input wire logic watchdog_clear_instr_i,
    input wire logic halt_i,
    input wire logic asleep_i,
    input wire logic wake_i,
    input wire logic wake_deep_i,
    input wire logic fast_crystal_i,
    input wire logic fast_startup_en_i,
    input wire logic low_volt_evt_i,
    // resets and clock controls
    output logic device_reset_o,
    output logic pc_sp_reset_o,
    output logic cpu_run_o,
    output logic sysclk_slow_rc_o,
    output logic periph_on_sub_o,
    output logic sub_clk_en_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // sub clock divider
    // ------------------------------------------------------------
    logic [15:0] div_r;
    logic sub_tick;
    logic [7:0] ctrl_r;
    logic [7:0] flags_r;
    logic [WDT_CNT_W-1:0] cnt_r;
    logic ovf_flag_r;
    logic pd_flag_r;
    logic [1:0] fault_cnt_r;
    logic fault_pend_r;
    logic [3:0] irq_st_r;
    logic [3:0] irq_mask_r;
    logic [1:0] osc_r;
    logic wait_fast_r;
    logic sysclk_slow_r;
    logic [7:0] rdata_r;
    settle_if st();
    // the slow RC runs on with the watchdog off: fault delay and settle need it
    wire div_wrap = (div_r == 16'(DIV - 1)); // [R1]

    wire [4:0] key = ctrl_r[KEY_LSB +: 5];
    wire key_on = (key == KEY_ENABLE); // [R3]
    wire key_off = (key == KEY_DISABLE); // [R3]
    wire key_bad = !key_on && !key_off;
    wire ctrl_wr = wr_i && (addr_i == ADDR_WDT_CONTROL);
    wire [4:0] new_key = wdata_i[KEY_LSB +: 5];
    wire bad_write = ctrl_wr && (new_key != KEY_ENABLE) && (new_key != KEY_DISABLE);
    wire [4:0] ovf_bit = timeout_bit(ctrl_r[SEL_LSB +: 3]); // [R2]
    wire overflow = key_on && cnt_r[ovf_bit]; // [R17]
    wire fault_fire = fault_pend_r && div_wrap && (fault_cnt_r == 2'(KEY_FAULT_TICKS - 1));
    wire flags_wr = wr_i && (addr_i == ADDR_RESET_FLAGS);
    wire irq_rd = rd_i && (addr_i == ADDR_IRQ_STATUS);
    wire [3:0] events = {st.slow_ready & ~osc_r[1], st.fast_ready & ~osc_r[0],
        fault_fire, overflow};

    // sub clock stands still while the watchdog is off, saving standby current
    assign sub_clk_en_o = key_on; // [R15]
    assign sub_tick = sub_clk_en_o && div_wrap; // [R1]

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            div_r <= 16'h0000;
        else if (div_wrap)
            div_r <= 16'h0000;
        else
            div_r <= div_r + 16'h0001;
    end

    // ------------------------------------------------------------
    // control register and watchdog counter
    // ------------------------------------------------------------
    // reset value carries the enable key, so the dog runs from power-on
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ctrl_r <= WDT_CONTROL_RST; // [R5]
        else if (fault_fire)
            ctrl_r <= WDT_CONTROL_RST;
        else if (ctrl_wr)
            ctrl_r <= wdata_i;
    end

    // clear sources take priority over counting
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_r <= '0;
        else if (bad_write || watchdog_clear_instr_i || halt_i || overflow || !key_on)
            cnt_r <= '0; // [R9]
        else if (sub_tick)
            cnt_r <= cnt_r + WDT_CNT_W'(1); // [R17]
    end

    // ------------------------------------------------------------
    // key fault delay and reset outputs
    // ------------------------------------------------------------
    // the fault reset waits two slow ticks, as the hardware guard does
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fault_pend_r <= 1'b0;
            fault_cnt_r <= 2'h0;
        end
        else if (fault_fire)
            fault_pend_r <= 1'b0;
        else if (key_bad && !fault_pend_r)
        begin
            fault_pend_r <= 1'b1; // [R4]
            fault_cnt_r <= 2'h0;
        end
        else if (fault_pend_r && div_wrap)
            fault_cnt_r <= fault_cnt_r + 2'h1;
    end

    // a bad key stops the sub clock, so the fault delay keeps its own tick
    assign device_reset_o = fault_fire || (overflow && !asleep_i); // [R4] [R7]
    assign pc_sp_reset_o = overflow && asleep_i; // [R8]

    // ------------------------------------------------------------
    // flags: timeout, power-down, reset flags register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ovf_flag_r <= 1'b0;
            pd_flag_r <= 1'b0;
        end
        else
        begin
            if (overflow)
                ovf_flag_r <= 1'b1; // [R7] [R8]
            else if (halt_i || watchdog_clear_instr_i)
                ovf_flag_r <= 1'b0;
            if (halt_i)
                pd_flag_r <= 1'b1; // [R16]
            else if (watchdog_clear_instr_i)
                pd_flag_r <= 1'b0; // [R16]
        end
    end

    // software may only write zeros to the fault flags; set wins over clear
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flags_r <= RESET_FLAGS_RST;
        else
        begin
            if (flags_wr)
            begin
                flags_r[FLAG_KEEP_IDLE_BIT] <= wdata_i[FLAG_KEEP_IDLE_BIT];
                flags_r[2:0] <= flags_r[2:0] & wdata_i[2:0];
            end
            flags_r[6:3] <= 4'h0; // [R10]
            if (fault_fire)
                flags_r[FLAG_KEY_FAULT_BIT] <= 1'b1; // [R6]
            if (low_volt_evt_i)
                flags_r[FLAG_LOW_VOLT_BIT] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // oscillator start and wake sequencing
    // ------------------------------------------------------------
    assign st.tick = div_wrap;
    assign st.fast_start = wake_i && wake_deep_i;
    assign st.slow_start = wake_i && wake_deep_i;

    osc_settle #(.SETTLE(SETTLE)) u_settle (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .st(st)
    );

    // cpu holds off until the fast oscillator is ready; slow may lag
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wait_fast_r <= 1'b0;
            sysclk_slow_r <= 1'b0;
            osc_r <= 2'h0;
        end
        else
        begin
            osc_r <= {st.slow_ready, st.fast_ready};
            if (st.fast_start)
                wait_fast_r <= 1'b1; // [R12]
            else if (st.fast_ready)
                wait_fast_r <= 1'b0;
            if (wake_i && !wake_deep_i && fast_crystal_i && fast_startup_en_i)
                sysclk_slow_r <= 1'b1; // [R13]
            else if (st.fast_ready)
                sysclk_slow_r <= 1'b0;
        end
    end

    assign cpu_run_o = !wait_fast_r && !asleep_i; // [R12]
    assign sysclk_slow_rc_o = sysclk_slow_r; // [R13]
    assign periph_on_sub_o = sysclk_slow_r; // [R14]

    // ------------------------------------------------------------
    // interrupts and read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_st_r <= 4'h0;
            irq_mask_r <= 4'h0;
        end
        else
        begin
            irq_st_r <= (irq_rd ? 4'h0 : irq_st_r) | events;
            if (wr_i && (addr_i == ADDR_IRQ_MASK))
                irq_mask_r <= wdata_i[3:0];
        end
    end

    // a mask bit of one holds its event back from the line
    assign irq_o = |(irq_st_r & ~irq_mask_r);

    wire [7:0] status_val = {3'h0, key_on, st.slow_ready, st.fast_ready,
        pd_flag_r, ovf_flag_r};
    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (addr_i)
            ADDR_WDT_CONTROL: rd_mux = ctrl_r;
            ADDR_RESET_FLAGS: rd_mux = flags_r & 8'h87; // [R10]
            ADDR_STATUS: rd_mux = status_val;
            ADDR_IRQ_STATUS: rd_mux = {4'h0, irq_st_r};
            ADDR_IRQ_MASK: rd_mux = {4'h0, irq_mask_r};
            ADDR_OSC_CTRL: rd_mux = {6'h00, sysclk_slow_r, wait_fast_r};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_r <= 8'h00;
        else if (rd_i)
            rdata_r <= rd_mux;
    end
    assign rdata_o = rdata_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence bad_key_seen;
        key_bad && !fault_pend_r;
    endsequence

    chk_key_fault_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4]
        fault_fire |-> ##1 flags_r[FLAG_KEY_FAULT_BIT] && ctrl_r == WDT_CONTROL_RST)
        else $error("key fault did not reset control or set flag");
    chk_bad_key_arm: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4]
        bad_key_seen |=> fault_pend_r)
        else $error("bad key did not arm fault delay");
    chk_fault_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
        flags_r[FLAG_KEY_FAULT_BIT] && !(flags_wr && !wdata_i[FLAG_KEY_FAULT_BIT])
        |=> flags_r[FLAG_KEY_FAULT_BIT])
        else $error("key fault flag dropped without software clear");
    chk_disable_key: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
        key_off |-> !sub_clk_en_o && !overflow)
        else $error("disabled watchdog still active");
    chk_run_overflow: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R7]
        overflow && !asleep_i |-> device_reset_o ##1 ovf_flag_r)
        else $error("run overflow did not reset");
    chk_sleep_overflow: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
        overflow && asleep_i |-> pc_sp_reset_o && !device_reset_o ##1 ovf_flag_r)
        else $error("sleep overflow wrong reset");
    chk_clear_counter: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
        watchdog_clear_instr_i || halt_i |=> cnt_r == '0)
        else $error("counter not cleared");
    chk_halt_pd: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R16]
        halt_i && !overflow |=> pd_flag_r && !ovf_flag_r)
        else $error("halt did not set power-down flag");
    chk_fast_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
        wait_fast_r && !st.fast_ready |-> !cpu_run_o)
        else $error("cpu ran before fast oscillator ready");
    chk_flag_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R10]
        rd_i && addr_i == ADDR_RESET_FLAGS |=> rdata_o[6:3] == 4'h0)
        else $error("unimplemented bits read nonzero");

    // ------------------------------------------------------------
    // wake and timing checks
    // ------------------------------------------------------------
    sequence deep_wake_seen;
        st.fast_start;
    endsequence

    // a deep wake parks the cpu from the next cycle, whatever the ready flag says
    chk_wake_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
        deep_wake_seen |=> !cpu_run_o)
        else $error("cpu ran right after deep wake");
    chk_slow_rc_wake: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R13]
        wake_i && !wake_deep_i && fast_crystal_i && fast_startup_en_i |=> sysclk_slow_rc_o)
        else $error("fast start wake kept fast clock");

    // chk_tick_gap holds only for a divider of four clocks or more, chk_fault_span for three or more
    chk_fault_span: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4]
        bad_key_seen |=> !fault_fire [*3])
        else $error("key fault reset too early");
    chk_tick_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
        sub_tick |=> !sub_tick [*3])
        else $error("sub ticks too close");
endmodule

//--- test/wdt_core_tb.sv
// self-checking testbench for the watchdog core
`timescale 1ns/10ps
module wdt_core_tb;
    import wdt_pkg::*;

    // --------------------------------------------------------------
    // clock, reset and design inputs
    // --------------------------------------------------------------
    localparam int DIV_TB = 4;
    logic clk_i, rst_n_i, wr_i, rd_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o, rv;
    logic watchdog_clear_instr_i, halt_i, asleep_i, wake_i, wake_deep_i;
    logic fast_crystal_i, fast_startup_en_i, low_volt_evt_i;
    logic device_reset_o, pc_sp_reset_o, cpu_run_o, sysclk_slow_rc_o;
    logic periph_on_sub_o, sub_clk_en_o, irq_o, dev, pcs;
    int err_total, compares, n;

    wdt_core #(.DIV(DIV_TB), .SETTLE(4)) u_wdt_core (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .watchdog_clear_instr_i(watchdog_clear_instr_i),
        .halt_i(halt_i), .asleep_i(asleep_i), .wake_i(wake_i),
        .wake_deep_i(wake_deep_i), .fast_crystal_i(fast_crystal_i),
        .fast_startup_en_i(fast_startup_en_i), .low_volt_evt_i(low_volt_evt_i),
        .device_reset_o(device_reset_o), .pc_sp_reset_o(pc_sp_reset_o),
        .cpu_run_o(cpu_run_o), .sysclk_slow_rc_o(sysclk_slow_rc_o),
        .periph_on_sub_o(periph_on_sub_o), .sub_clk_en_o(sub_clk_en_o), .irq_o(irq_o));

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // --------------------------------------------------------------
    // bus, pulse and compare helpers
    // --------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // read data appear in the cycle after the strobe and hold until the next read, so sample there
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic pulse_clr();
        @(posedge clk_i);
        watchdog_clear_instr_i <= 1'b1;
        @(posedge clk_i);
        watchdog_clear_instr_i <= 1'b0;
    endtask

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        compares++;
        if (g < lo || g > hi)
        begin
            err_total++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    // counts cycles until either reset output pulses, or the limit runs out
    task automatic wait_evt(input int limit);
        n = 0;
        dev = 1'b0;
        pcs = 1'b0;
        while (n < limit && !dev && !pcs)
        begin
            @(posedge clk_i);
            #1;
            n++;
            dev = (device_reset_o === 1'b1);
            pcs = (pc_sp_reset_o === 1'b1);
        end
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        rd(ADDR_WDT_CONTROL, rv);
        chk8("control after reset", 8'h53, rv);
        rd(ADDR_RESET_FLAGS, rv);
        chk8("flags after reset", 8'h00, rv);
        chk8("sub clock enable", 8'h01, {7'h00, sub_clk_en_o});
        rd(ADDR_STATUS, rv);
        chk8("watchdog on", 8'h01, {7'h00, rv[ST_WDT_ON_BIT]});
        rd(ADDR_IRQ_STATUS, rv);
        wr(4'hf, 8'hff);
        rd(4'hf, rv);
        chk8("unmapped read", 8'h00, rv);
    endtask

    // overflow span depends on select; irq masked then unmasked, then cleared by read
    task automatic t_timeout(input logic [2:0] sel, input int ticks);
        wr(ADDR_IRQ_MASK, 8'hff);
        wr(ADDR_WDT_CONTROL, {KEY_ENABLE, sel});
        pulse_clr();
        wait_evt(ticks * DIV_TB + 64);
        chk_rng("overflow cycles", ticks * DIV_TB - 8, ticks * DIV_TB + 8, n);
        chk8("full reset on overflow", 8'h02, {6'h00, dev, pcs});
        rd(ADDR_STATUS, rv);
        chk8("timeout flag", 8'h01, {7'h00, rv[ST_OVERFLOW_BIT]});
        chk8("irq masked", 8'h00, {7'h00, irq_o});
        wr(ADDR_IRQ_MASK, 8'h00);
        @(posedge clk_i);
        #1;
        chk8("irq unmasked", 8'h01, {7'h00, irq_o});
        rd(ADDR_IRQ_STATUS, rv);
        chk8("irq overflow event", 8'h01, {7'h00, rv[EV_OVERFLOW]});
        #1;
        chk8("irq after read", 8'h00, {7'h00, irq_o});
    endtask

    task automatic t_halt();
        @(posedge clk_i);
        halt_i <= 1'b1;
        @(posedge clk_i);
        halt_i <= 1'b0;
        rd(ADDR_STATUS, rv);
        chk8("halt flags", 8'h02, {6'h00, rv[ST_POWER_DOWN_BIT], rv[ST_OVERFLOW_BIT]});
        pulse_clr();
        rd(ADDR_STATUS, rv);
        chk8("power down cleared", 8'h00, {7'h00, rv[ST_POWER_DOWN_BIT]});
    endtask

    // regular clears keep the shortest timeout from ever firing
    task automatic t_clear();
        wr(ADDR_WDT_CONTROL, {KEY_ENABLE, 3'h0});
        pulse_clr();
        repeat (3)
        begin
            wait_evt(900);
            chk8("no reset while cleared", 8'h00, {6'h00, dev, pcs});
            pulse_clr();
        end
    endtask

    task automatic t_disable();
        wr(ADDR_WDT_CONTROL, {KEY_DISABLE, 3'h0});
        @(posedge clk_i);
        #1;
        chk8("sub clock stopped", 8'h00, {7'h00, sub_clk_en_o});
        wait_evt(1500);
        chk8("disabled no reset", 8'h00, {6'h00, dev, pcs});
        rd(ADDR_STATUS, rv);
        chk8("watchdog off", 8'h00, {7'h00, rv[ST_WDT_ON_BIT]});
    endtask

    task automatic t_sleep();
        @(posedge clk_i);
        asleep_i <= 1'b1;
        wr(ADDR_WDT_CONTROL, {KEY_ENABLE, 3'h0});
        pulse_clr();
        wait_evt(256 * DIV_TB + 64);
        chk8("sleep overflow pc sp only", 8'h01, {6'h00, dev, pcs});
        rd(ADDR_STATUS, rv);
        chk8("sleep timeout flag", 8'h01, {7'h00, rv[ST_OVERFLOW_BIT]});
        @(posedge clk_i);
        asleep_i <= 1'b0;
    endtask

    // a bad key forces a reset a few slow ticks later and leaves a sticky flag
    task automatic t_fault();
        wr(ADDR_WDT_CONTROL, 8'h00);
        wait_evt(40);
        chk_rng("key fault delay", 2 * DIV_TB - 4, 3 * DIV_TB + 4, n);
        chk8("key fault reset", 8'h02, {6'h00, dev, pcs});
        rd(ADDR_WDT_CONTROL, rv);
        chk8("control restored", 8'h53, rv);
        @(posedge clk_i);
        low_volt_evt_i <= 1'b1;
        @(posedge clk_i);
        low_volt_evt_i <= 1'b0;
        wr(ADDR_RESET_FLAGS, 8'hff);
        rd(ADDR_RESET_FLAGS, rv);
        chk8("flags sticky, gap zero", 8'h85, rv);
        wr(ADDR_RESET_FLAGS, 8'h00);
        rd(ADDR_RESET_FLAGS, rv);
        chk8("flags cleared by zero", 8'h00, rv);
    endtask

    // a plain wake may run on the slow RC; a deep wake waits for the fast settle
    task automatic t_wake();
        @(posedge clk_i);
        {wake_i, fast_crystal_i, fast_startup_en_i} <= 3'h7;
        @(posedge clk_i);
        wake_i <= 1'b0;
        @(posedge clk_i);
        {wake_i, wake_deep_i} <= 2'h3;
        #1;
        chk8("slow rc", 8'h03, {6'h00, sysclk_slow_rc_o, periph_on_sub_o});
        @(posedge clk_i);
        wake_i <= 1'b0;
        #1;
        chk8("cpu held", 8'h00, {7'h00, cpu_run_o});
        for (n = 0; n < 40 && cpu_run_o !== 1'b1; n++)
        begin
            @(posedge clk_i);
            #1;
        end
        chk_rng("fast settle cycles", 4 * DIV_TB - 4, 4 * DIV_TB + 4, n);
        rd(ADDR_STATUS, rv);
        chk8("fast before slow", 8'h01, {6'h00, rv[ST_FAST_READY_BIT +: 2]});
        repeat (24) @(posedge clk_i);
        rd(ADDR_STATUS, rv);
        chk8("both settled", 8'h03, {6'h00, rv[ST_FAST_READY_BIT +: 2]});
        chk8("irq pending", 8'h01, {7'h00, irq_o});
        rd(ADDR_IRQ_STATUS, rv);
        chk8("irq events", 8'h0f, rv);
    endtask

    // --------------------------------------------------------------
    // verdict, watchdog and main sequence
    // --------------------------------------------------------------
    task automatic results();
        $display("checks %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // sized well past the roughly 30k cycles the scenarios need
    initial
    begin
        #400000;
        err_total++;
        results();
    end

    initial
    begin
        {wr_i, rd_i, watchdog_clear_instr_i, halt_i, asleep_i, wake_i, wake_deep_i} = 7'h00;
        {fast_crystal_i, fast_startup_en_i, low_volt_evt_i} = 3'h0;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        err_total = 0;
        compares = 0;
        rst_n_i = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_timeout(3'h0, 256);
        t_timeout(3'h1, 1024);
        t_timeout(3'h2, 4096);
        t_halt();
        t_clear();
        t_disable();
        t_sleep();
        t_fault();
        t_wake();
        results();
    end
endmodule
